// [cca_assist.sv]
// Communication check-character assist: LRC / CRC-16 / SDLC residuals on APB
`timescale 1ns/1ps

module cca_assist
   import cca_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   input  wire logic        CLK_EN,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   // ----------------------------------------------------------------------
   // Table entry, computed bitwise instead of a stored ROM image
   // ----------------------------------------------------------------------
   function automatic logic [15:0] cca_tbl_entry(input logic [7:0] idx,
                                                 input logic       page);
      logic [15:0] c;
      logic [15:0] p;
      c = {8'h00, idx};
      p = page ? CCA_POLY_BSC : CCA_POLY_SDLC;
      for (int i = 0; i < CCA_TBL_BITS; i++)
      begin
         c = c[0] ? ((c >> 1) ^ p) : (c >> 1);
      end
      return c;
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   cca_steer_t  steer_q,     steer_d;
   logic [7:0]  format_select_reg_q, format_select_reg_d;
   logic [15:0] residual_check_reg_q, residual_check_reg_d;
   logic [7:0]  current_char_reg_q,  current_char_reg_d;
   logic        box_active_timer_q, box_active_timer_d;
   logic        pready_q,    pready_d;
   logic        pslverr_q,   pslverr_d;
   logic [31:0] prdata_q,    prdata_d;

   // ----------------------------------------------------------------------
   // Decode and datapath
   // ----------------------------------------------------------------------
   logic        access;
   logic        hit_data;
   logic        hit_resid;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        mapped;
   logic        assist_control_strobe;
   logic        sequence_clear_enable;
   logic        host_ack_strobe;
   logic        table_page_select;
   logic        lrc_mode;
   logic [7:0]  xor_byte;
   logic [15:0] table_word;
   logic [15:0] new_resid;
   logic [7:0]  assist_low_byte_lines;
   logic [31:0] resid_word;

   // Busy cycles stretch the access, so no second write can slip in
   assign access    = PSEL && PENABLE && !pready_q && !box_active_timer_q;
   assign hit_data  = (PADDR == CCA_OFF_DATA);
   assign hit_resid = (PADDR == CCA_OFF_RESID);
   assign hit_ctrl  = (PADDR == CCA_OFF_CTRL);
   assign hit_stat  = (PADDR == CCA_OFF_STATUS);
   assign mapped    = hit_data || hit_resid || hit_ctrl || hit_stat;

   assign assist_control_strobe = access && PWRITE && hit_data;
   assign sequence_clear_enable = access && PWRITE && hit_ctrl
                                  && PWDATA[CCA_CTRL_CLR_BIT];
   assign host_ack_strobe       = access && !PWRITE
                                  && (hit_data || hit_resid);

   assign lrc_mode          = (format_select_reg_q == CCA_FMT_LRC);
   assign table_page_select = !format_select_reg_q[CCA_PAGE_FMT_BIT];
   assign xor_byte   = PWDATA[7:0] ^ residual_check_reg_q[7:0];
   assign table_word = cca_tbl_entry(xor_byte, table_page_select);

   always_comb
   begin
      if (lrc_mode)
      begin
         new_resid = {residual_check_reg_q[15:8], xor_byte};
      end
      else
      begin
         new_resid = {table_word[15:8],
                      table_word[7:0] ^ residual_check_reg_q[15:8]};
      end
   end

   // Both bytes go straight to the bus, the low byte via assist_low_byte_lines with no mux
   assign assist_low_byte_lines = residual_check_reg_q[7:0];
   assign resid_word = {16'h0000, residual_check_reg_q[15:8],
                        assist_low_byte_lines};

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      steer_d              = steer_q;
      format_select_reg_d  = format_select_reg_q;
      residual_check_reg_d = residual_check_reg_q;
      current_char_reg_d   = current_char_reg_q;
      box_active_timer_d   = 1'b0;
      pready_d             = 1'b0;
      pslverr_d            = 1'b0;
      prdata_d             = prdata_q;
      if (box_active_timer_q)
      begin
         // Delayed load into the steered register
         pready_d = 1'b1;
         unique case (steer_q)
            CCA_ST_FMT:
            begin
               format_select_reg_d = PWDATA[7:0];
               steer_d             = CCA_ST_RES;
            end
            CCA_ST_RES:
            begin
               residual_check_reg_d = PWDATA[15:0];
               steer_d              = CCA_ST_CHAR;
            end
            CCA_ST_CHAR:
            begin
               current_char_reg_d   = PWDATA[7:0];
               residual_check_reg_d = new_resid;
               steer_d              = CCA_ST_CHAR;
            end
            default:
            begin
               steer_d = CCA_ST_FMT;
            end
         endcase
      end
      else if (access)
      begin
         box_active_timer_d = assist_control_strobe;
         pready_d           = !assist_control_strobe;
         pslverr_d          = !mapped;
         if (sequence_clear_enable)
         begin
            steer_d = CCA_ST_FMT;
         end
         if (host_ack_strobe)
         begin
            prdata_d = resid_word;
         end
         else if (!PWRITE && hit_stat)
         begin
            prdata_d = {16'h0000, format_select_reg_q, 6'h00,
                        steer_q};
         end
         else if (!PWRITE)
         begin
            prdata_d = CCA_DATA_RST;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         steer_q              <= CCA_ST_FMT;
         format_select_reg_q  <= CCA_FMT_RST;
         residual_check_reg_q <= CCA_RESID_RST;
         current_char_reg_q   <= CCA_CHAR_RST;
         box_active_timer_q   <= 1'b0;
         pready_q             <= 1'b0;
         pslverr_q            <= 1'b0;
         prdata_q             <= CCA_DATA_RST;
      end
      else if (CLK_EN)
      begin
         steer_q              <= steer_d;
         format_select_reg_q  <= format_select_reg_d;
         residual_check_reg_q <= residual_check_reg_d;
         current_char_reg_q   <= current_char_reg_d;
         box_active_timer_q   <= box_active_timer_d;
         pready_q             <= pready_d;
         pslverr_q            <= pslverr_d;
         prdata_q             <= prdata_d;
      end
   end

   assign PRDATA  = prdata_q;
   assign PREADY  = pready_q;
   assign PSLVERR = pslverr_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESET_N);

   a_fmt_lrc_code: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_CHAR
      && format_select_reg_q == CCA_FMT_LRC
      |=> residual_check_reg_q == {$past(residual_check_reg_q[15:8]),
          $past(PWDATA[7:0]) ^ $past(residual_check_reg_q[7:0])})
      else $error("LRC format code did not select the LRC fold");

   a_fmt_steer_load: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_FMT
      |=> format_select_reg_q == $past(PWDATA[7:0])
          && steer_q == CCA_ST_RES)
      else $error("Format write not steered to format register");

   a_resid_preload: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_RES
      |=> residual_check_reg_q == $past(PWDATA[15:0])
          && steer_q == CCA_ST_CHAR)
      else $error("Residual preload not taken");

   a_char_hold: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_CHAR
      |=> steer_q == CCA_ST_CHAR
          && current_char_reg_q == $past(PWDATA[7:0]))
      else $error("Steering left character state");

   a_seq_clear: assert property (
      CLK_EN && sequence_clear_enable |=> steer_q == CCA_ST_FMT)
      else $error("Sequence clear did not reset steering");

   a_strobe_pulse: assert property (
      CLK_EN && assist_control_strobe
      |=> box_active_timer_q && !PREADY)
      else $error("Data strobe gave no internal pulse");

   a_done_ready: assert property (
      CLK_EN && box_active_timer_q |=> PREADY && !box_active_timer_q)
      else $error("Update not finished before ready");

   a_lrc_fold: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_CHAR
      && lrc_mode
      |=> residual_check_reg_q[15:8] == $past(residual_check_reg_q[15:8])
          && residual_check_reg_q[7:0] == $past(xor_byte))
      else $error("LRC fold wrong");

   a_crc_fold: assert property (
      CLK_EN && box_active_timer_q && steer_q == CCA_ST_CHAR
      && !lrc_mode
      |=> residual_check_reg_q == {$past(table_word[15:8]),
          $past(table_word[7:0]) ^ $past(residual_check_reg_q[15:8])})
      else $error("CRC fold wrong");

   a_page_sel: assert property (
      (format_select_reg_q == CCA_FMT_BSC) |-> table_page_select)
      else $error("CRC-16 format did not select high page");

   a_ack_read: assert property (
      CLK_EN && host_ack_strobe
      |=> PREADY && PRDATA[15:0] == $past(residual_check_reg_q))
      else $error("Acknowledge read did not return residual");

   a_reset_state: assert property (
      !$past(RESET_N) |-> steer_q == CCA_ST_FMT
                          && format_select_reg_q == CCA_FMT_RST)
      else $error("Reset left steering or format set");

   c_lrc_char: cover property (
      box_active_timer_q && steer_q == CCA_ST_CHAR && lrc_mode);
   c_sdlc_char: cover property (
      box_active_timer_q && steer_q == CCA_ST_CHAR
      && format_select_reg_q == CCA_FMT_SDLC);
   c_back_to_back: cover property (
      box_active_timer_q && steer_q == CCA_ST_CHAR ##[2:8]
      box_active_timer_q && steer_q == CCA_ST_CHAR);
   c_clear_seq: cover property (
      sequence_clear_enable && steer_q == CCA_ST_CHAR);

endmodule

// [cca_host_model.sv]
// Host processor model driving the assist over APB
`timescale 1ns/1ps

module cca_host_model
   import cca_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // One bus cycle; format, residual and character writes all use it
   // ---------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd,
      output logic err, output logic ok);
      ok  = 1'b0;
      rd  = 32'h0000_0000;
      err = 1'b0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (int n = 0; n < 20 && !ok; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
         begin
            ok  = 1'b1;
            rd  = prdata;
            err = pslverr;
         end
      end
      // Released lines flip so stale data cannot pass for fresh
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~wd;
   endtask
endmodule

// [cca_pkg.sv]
// Constants and types shared by the communication check-character assist
package cca_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CCA_OFF_DATA   = 8'h00;
   localparam logic [7:0] CCA_OFF_RESID  = 8'h04;
   localparam logic [7:0] CCA_OFF_CTRL   = 8'h08;
   localparam logic [7:0] CCA_OFF_STATUS = 8'h0C;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CCA_CTRL_CLR_BIT  = 0;
   localparam int CCA_PAGE_FMT_BIT  = 0;
   localparam int CCA_STAT_FMT_LSB  = 8;

   // ----------------------------------------------------------------------
   // Format codes, table polynomials, reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  CCA_FMT_BSC   = 8'h00;
   localparam logic [7:0]  CCA_FMT_SDLC  = 8'h01;
   localparam logic [7:0]  CCA_FMT_LRC   = 8'h02;
   localparam logic [15:0] CCA_POLY_BSC  = 16'hA001;
   localparam logic [15:0] CCA_POLY_SDLC = 16'h8408;
   localparam logic [7:0]  CCA_FMT_RST   = 8'h00;
   localparam logic [15:0] CCA_RESID_RST = 16'h0000;
   localparam logic [7:0]  CCA_CHAR_RST  = 8'h00;
   localparam logic [31:0] CCA_DATA_RST  = 32'h0000_0000;
   localparam int          CCA_TBL_BITS  = 8;

   // ----------------------------------------------------------------------
   // Steering states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      CCA_ST_FMT,
      CCA_ST_RES,
      CCA_ST_CHAR
   } cca_steer_t;

endpackage

// [tb_top.sv]
// Self-checking bench for the check-character assist
`timescale 1ns/1ps

module tb_top
   import cca_pkg::*;
();
   logic        sys_clk;
   logic        reset_n;
   logic        clk_en;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] rng;
   int          err_count;
   int          comparisons;
   int          resid;
   int          fmt;
   logic [7:0]  fmts [3] = '{CCA_FMT_BSC, CCA_FMT_SDLC, CCA_FMT_LRC};
   int          exp_q [$];

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   cca_assist dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr));

   cca_host_model host_u (.clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic int tbl(input int page, input int idx);
      int c;
      int p;
      p = page ? int'(CCA_POLY_BSC) : int'(CCA_POLY_SDLC);
      c = idx;
      for (int i = 0; i < 8; i++)
         c = (c & 1) ? ((c >> 1) ^ p) : (c >> 1);
      return c;
   endfunction

   function automatic int fold(input int r, input int f, input int ch);
      int x;
      int t;
      x = (r ^ ch) & 32'h0000_00ff;
      if (f == 2)
         return (r & 32'h0000_ff00) | x;
      t = tbl((f & 1) == 0, x);
      return (t & 32'h0000_ff00) | ((t ^ (r >> 8)) & 32'h0000_00ff);
   endfunction

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // ---------------------------------------------------------------
   // Checks and bus helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, input logic eerr, output logic [31:0] rd);
      logic e;
      logic ok;
      host_u.xfer(wr, a, wd, rd, e, ok);
      if (!ok)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         test_done();
      end
      check({31'h0000_0000, e}, {31'h0000_0000, eerr});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, 1'b0, rd);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0000_0000, 1'b0, rd);
      check(rd, exp);
   endtask

   task automatic start(input logic [7:0] f, input logic [15:0] r0);
      wr(CCA_OFF_DATA, {24'h00_0000, f});
      rd_chk(CCA_OFF_STATUS, {16'h0000, f, 6'h00, CCA_ST_RES});
      wr(CCA_OFF_DATA, {16'h0000, r0});
      fmt   = f;
      resid = r0;
      rd_chk(CCA_OFF_RESID, 32'(resid));
   endtask

   task automatic chr(input logic [31:0] c, input logic look);
      wr(CCA_OFF_DATA, c);
      resid = fold(resid, fmt, int'(c[7:0]));
      exp_q.push_back(resid);
      if (look)
      begin
         rd_chk(CCA_OFF_RESID, 32'(exp_q[$]));
         exp_q.delete();
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic [31:0] c;
      logic [31:0] got;
      reset_n     = 1'b0;
      clk_en      = 1'b1;
      rng         = 32'h0000_ff81;
      err_count   = 0;
      comparisons = 0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(CCA_OFF_STATUS, 32'h0000_0000);
      rd_chk(CCA_OFF_RESID, 32'h0000_0000);
      start(CCA_FMT_LRC, 16'h0000);
      chr(32'h0000_0001, 1'b1);
      chr(32'h0000_0003, 1'b1);
      rd_chk(CCA_OFF_RESID, 32'h0000_0002);
      wr(CCA_OFF_CTRL, 32'h0000_0001);
      start(CCA_FMT_BSC, 16'h0000);
      chr(32'h0000_0001, 1'b1);
      rd_chk(CCA_OFF_DATA, 32'h0000_c0c1);
      // Enable dropped mid-access must only stretch the transfer
      fork
         chr(32'h0000_0002, 1'b1);
         begin
            repeat (2) @(posedge sys_clk);
            clk_en <= 1'b0;
            repeat (3) @(posedge sys_clk);
            clk_en <= 1'b1;
         end
      join
      for (int k = 0; k < 3; k++)
      begin
         wr(CCA_OFF_CTRL, 32'h0000_0001);
         c = xs();
         start(fmts[k], c[15:0]);
         for (int j = 0; j < 24; j++)
            chr(xs(), j[0]);
         rd_chk(CCA_OFF_DATA, 32'(resid));
         rd_chk(CCA_OFF_STATUS, {16'h0000, fmts[k], 6'h00, CCA_ST_CHAR});
      end
      c = xs();
      wr(CCA_OFF_RESID, c);
      bus(1'b0, 8'h10, c, 1'b1, got);
      bus(1'b1, 8'h14, c, 1'b1, got);
      rd_chk(CCA_OFF_RESID, 32'(resid));
      rd_chk(CCA_OFF_CTRL, 32'h0000_0000);
      wr(CCA_OFF_CTRL, 32'h0000_0001);
      wr(CCA_OFF_DATA, {24'h00_0000, CCA_FMT_LRC});
      wr(CCA_OFF_CTRL, 32'h0000_0001);
      start(CCA_FMT_SDLC, 16'hffff);
      chr(32'h0000_00a5, 1'b0);
      chr(32'h0000_005a, 1'b1);
      // Mid-run reset from character state with a live format
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(CCA_OFF_STATUS, 32'h0000_0000);
      rd_chk(CCA_OFF_RESID, 32'h0000_0000);
      start(CCA_FMT_LRC, 16'h1234);
      chr(32'h0000_00f0, 1'b1);
      test_done();
   end
endmodule
